// File: pkg/hpcr_pkg.sv
package hpcr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_PLL_IN_DIV   = 8'h3E;
  localparam logic [7:0] OFF_RSVD_LO      = 8'h40;
  localparam logic [7:0] OFF_RSVD_HI      = 8'h41;
  localparam logic [7:0] OFF_SPI_DIV      = 8'h60;
  localparam logic [7:0] OFF_SPI_EN       = 8'h61;
  localparam logic [7:0] OFF_TW_DIV       = 8'h62;
  localparam logic [7:0] OFF_TW_EN        = 8'h63;
  localparam logic [7:0] OFF_PAGE_LO      = 8'h80;
  localparam logic [7:0] OFF_PAGE_HI      = 8'h81;
  localparam logic [7:0] OFF_ADDR_MASK    = 8'h82;
  localparam logic [7:0] OFF_OWNERSHIP    = 8'h84;
  localparam logic [7:0] OFF_RD_SETUP     = 8'h85;
  localparam logic [7:0] OFF_DBG_RESET    = 8'h8A;
  localparam logic [7:0] OFF_AUTO_INC     = 8'hA6;
  localparam logic [7:0] OFF_RW_ADDR0     = 8'hA8;
  localparam logic [7:0] OFF_RW_ADDR3     = 8'hAB;
  localparam logic [7:0] OFF_DATA_LO      = 8'hAC;
  localparam logic [7:0] OFF_DATA_HI      = 8'hAD;
  localparam logic [7:0] OFF_ASYNC_FIRST  = 8'h20;
  localparam logic [7:0] OFF_ASYNC_LAST   = 8'h3F;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int         BIT_PLL_DIV_EN   = 0;
  localparam int         BIT_PIN_STATUS   = 4;
  localparam int         BIT_SRC_SEL      = 2;
  localparam int         BIT_CLK_EN       = 0;
  localparam int         BIT_DBG_PINS     = 1;
  localparam int         BIT_SOFT_RESET   = 0;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_RD_SETUP     = 8'h04;
  localparam logic [7:0] MASK_DIV4        = 8'h0F;
  localparam logic [7:0] MASK_PLL         = 8'h07;
  localparam logic [7:0] MASK_EN          = 8'h05;
  localparam logic [7:0] MASK_MASK5       = 8'h1F;
  localparam logic [7:0] MASK_SETUP       = 8'h07;
  localparam logic [7:0] MASK_DBG         = 8'h03;
  localparam logic [7:0] MASK_BIT0        = 8'h01;
  localparam logic [15:0] INDIRECT_ASYNC_PAGE = 16'h3800;
endpackage

// File: pkg/hpcr_div_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hpcr_div_if;
  logic [3:0] ratio;
  logic       run;
  logic       tick;
  modport ctrl (output ratio, output run, input tick);
  modport div  (input ratio, input run, output tick);
endinterface
`default_nettype wire

// File: design/hpcr_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// divide-by-(ratio+1) enable generator
// ----------------------------------------
module hpcr_clk_div (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // control
  hpcr_div_if.div   dv
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       tick_reg;
  logic       tick_next;

  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!dv.run) begin
      cnt_next = 4'h0;
    end else if (cnt_reg >= dv.ratio) begin
      cnt_next  = 4'h0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign dv.tick = tick_reg;
endmodule
`default_nettype wire

// File: design/hpcr_regs.sv
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// RULE1: software clears enable before changing ratio
// RULE2: enable zero passes input clock undivided
// RULE3: software never writes reserved 40h, 41h
// RULE4: serial clock divides system clock by field+1
// RULE5: software keeps serial clock above host clock
// RULE6: serial source select, pin forces input clock
// RULE7: serial enable gates only divided source
// RULE8: two-wire clock divides by field+1
// RULE9: software keeps two-wire clock above limits
// RULE10: two-wire pin forces input clock one
// RULE11: page bytes supply high address bits
// RULE12: mask bits form address bits 20-16
// RULE13: ownership governs only async range writes
// RULE14: ownership zero blocks direct host writes
// RULE15: ownership one blocks internal bus writes
// RULE16: read setup cycles field, default four
// RULE17: debug bit reassigns second panel pins; code does so only while host_is_direct16_not_handheld is high
// RULE18: auto increment advances address after access
// RULE19: data port accesses address register location
// RULE20: soft reset sequence done by software
module hpcr_regs (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // host register port
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  // internal bus write port to async range
  input  wire logic        internal_bus_wr,
  input  wire logic [7:0]  internal_bus_addr,
  input  wire logic [7:0]  internal_bus_wdata,
  // pins
  input  wire logic        periph_clock_select_pin,
  input  wire logic        two_wire_clock_select_pin,
  input  wire logic        periph_clock_enable_pin,
  input  wire logic        two_wire_clock_enable_pin,
  input  wire logic        input_clock_one_tick,
  input  wire logic        host_is_direct16_not_handheld,
  // clock and control outputs
  output logic             first_pll_div_en,
  output logic      [1:0]  first_pll_div_sel,
  output logic             periph_clk_tick,
  output logic             two_wire_clk_tick,
  output logic      [31:0] direct_addr_high,
  output logic      [4:0]  upper_addr_mask_field,
  output logic             async_host_owner,
  output logic      [2:0]  read_setup_cycles,
  output logic             debug_pins_sel,
  output logic             soft_reset,
  output logic      [31:0] indirect_addr,
  output logic             indirect_wr,
  output logic             indirect_rd,
  output logic      [15:0] indirect_wdata,
  output logic      [7:0]  async_wr_addr,
  output logic      [7:0]  async_wr_data,
  output logic             async_wr
);
  import hpcr_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0]  pll_reg, pll_next;
  logic [7:0]  spi_div_reg, spi_div_next;
  logic [7:0]  spi_en_reg, spi_en_next;
  logic [7:0]  tw_div_reg, tw_div_next;
  logic [7:0]  tw_en_reg, tw_en_next;
  logic [7:0]  page_lo_reg, page_lo_next;
  logic [7:0]  page_hi_reg, page_hi_next;
  logic [7:0]  mask_reg, mask_next;
  logic [7:0]  own_reg, own_next;
  logic [7:0]  setup_reg, setup_next;
  logic [7:0]  dbg_reg, dbg_next;
  logic [7:0]  inc_reg, inc_next;
  logic [31:0] addr_reg, addr_next;
  logic [15:0] wdat_reg, wdat_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        iwr_reg, iwr_next;
  logic        ird_reg, ird_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic [7:0]  aw_data_reg, aw_data_next;
  logic        aw_reg, aw_next;

  function automatic logic in_async(input logic [7:0] a);
    in_async = (a >= OFF_ASYNC_FIRST) && (a <= OFF_ASYNC_LAST);
  endfunction

  // data port address step, two bytes per access when enabled
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic on);
    step_addr = on ? a + 32'h0000_0002 : a;
  endfunction

  logic host_async_ok;
  logic bus_async_ok;
  assign host_async_ok = own_reg[0];                        // see RULE14
  assign bus_async_ok  = !own_reg[0];                       // see RULE15

  always_comb begin
    pll_next     = pll_reg;
    spi_div_next = spi_div_reg;
    spi_en_next  = spi_en_reg;
    tw_div_next  = tw_div_reg;
    tw_en_next   = tw_en_reg;
    page_lo_next = page_lo_reg;
    page_hi_next = page_hi_reg;
    mask_next    = mask_reg;
    own_next     = own_reg;
    setup_next   = setup_reg;
    dbg_next     = dbg_reg;
    inc_next     = inc_reg;
    addr_next    = addr_reg;
    wdat_next    = wdat_reg;
    rdata_next   = rdata_reg;
    iwr_next     = 1'b0;
    ird_next     = 1'b0;
    aw_addr_next = aw_addr_reg;
    aw_data_next = aw_data_reg;
    aw_next      = 1'b0;
    // internal bus writes to the async range
    if (internal_bus_wr && in_async(internal_bus_addr) && bus_async_ok) begin // see RULE15
      aw_next      = 1'b1;
      aw_addr_next = internal_bus_addr;
      aw_data_next = internal_bus_wdata;
      if (internal_bus_addr == OFF_PLL_IN_DIV) begin
        pll_next = internal_bus_wdata & MASK_PLL;
      end
    end
    if (host_wr) begin
      if (in_async(host_addr)) begin
        if (host_async_ok) begin                            // see RULE13
          aw_next      = 1'b1;
          aw_addr_next = host_addr;
          aw_data_next = host_wdata;
          if (host_addr == OFF_PLL_IN_DIV) begin
            pll_next = host_wdata & MASK_PLL;               // see RULE1
          end
        end
      end else begin
        unique case (host_addr)
          OFF_SPI_DIV:   spi_div_next = host_wdata & MASK_DIV4;
          OFF_SPI_EN:    spi_en_next  = host_wdata & MASK_EN;
          OFF_TW_DIV:    tw_div_next  = host_wdata & MASK_DIV4;
          OFF_TW_EN:     tw_en_next   = host_wdata & MASK_EN;
          OFF_PAGE_LO:   page_lo_next = host_wdata;
          OFF_PAGE_HI:   page_hi_next = host_wdata;
          OFF_ADDR_MASK: mask_next    = host_wdata & MASK_MASK5;
          OFF_OWNERSHIP: own_next     = host_wdata & MASK_BIT0;
          OFF_RD_SETUP:  setup_next   = host_wdata & MASK_SETUP;
          OFF_DBG_RESET: dbg_next     = host_wdata & MASK_DBG;
          OFF_AUTO_INC:  inc_next     = host_wdata & MASK_BIT0;
          8'hA8:         addr_next[7:0]   = host_wdata;
          8'hA9:         addr_next[15:8]  = host_wdata;
          8'hAA:         addr_next[23:16] = host_wdata;
          OFF_RW_ADDR3:  addr_next[31:24] = host_wdata;
          OFF_DATA_LO:   wdat_next[7:0]   = host_wdata;
          OFF_DATA_HI: begin
            wdat_next[15:8] = host_wdata;
            iwr_next        = 1'b1;                         // see RULE19
            addr_next       = step_addr(addr_reg, inc_reg[0]); // see RULE18
          end
          default: ;
        endcase
      end
    end else if (host_rd) begin
      unique case (host_addr)
        OFF_PLL_IN_DIV: rdata_next = pll_reg;
        OFF_SPI_DIV:    rdata_next = spi_div_reg;
        OFF_SPI_EN:     rdata_next = spi_en_reg | {3'h0, periph_clock_enable_pin, 4'h0};
        OFF_TW_DIV:     rdata_next = tw_div_reg;
        OFF_TW_EN:      rdata_next = tw_en_reg | {3'h0, two_wire_clock_enable_pin, 4'h0};
        OFF_PAGE_LO:    rdata_next = page_lo_reg;
        OFF_PAGE_HI:    rdata_next = page_hi_reg;
        OFF_ADDR_MASK:  rdata_next = mask_reg;
        OFF_OWNERSHIP:  rdata_next = own_reg;
        OFF_RD_SETUP:   rdata_next = setup_reg;
        OFF_DBG_RESET:  rdata_next = dbg_reg;
        OFF_AUTO_INC:   rdata_next = inc_reg;
        8'hA8:          rdata_next = addr_reg[7:0];
        8'hA9:          rdata_next = addr_reg[15:8];
        8'hAA:          rdata_next = addr_reg[23:16];
        OFF_RW_ADDR3:   rdata_next = addr_reg[31:24];
        OFF_DATA_LO: begin
          rdata_next = 8'h00;
          ird_next   = 1'b1;                                // see RULE19
          addr_next  = step_addr(addr_reg, inc_reg[0]);     // see RULE18
        end
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_reg     <= RST_ZERO;
      spi_div_reg <= RST_ZERO;
      spi_en_reg  <= RST_ZERO;
      tw_div_reg  <= RST_ZERO;
      tw_en_reg   <= RST_ZERO;
      page_lo_reg <= RST_ZERO;
      page_hi_reg <= RST_ZERO;
      mask_reg    <= RST_ZERO;
      own_reg     <= RST_ZERO;
      setup_reg   <= RST_RD_SETUP;                          // see RULE16
      dbg_reg     <= RST_ZERO;
      inc_reg     <= RST_ZERO;
      addr_reg    <= 32'h0000_0000;
      wdat_reg    <= 16'h0000;
      rdata_reg   <= RST_ZERO;
      iwr_reg     <= 1'b0;
      ird_reg     <= 1'b0;
      aw_addr_reg <= RST_ZERO;
      aw_data_reg <= RST_ZERO;
      aw_reg      <= 1'b0;
    end else begin
      pll_reg     <= pll_next;
      spi_div_reg <= spi_div_next;
      spi_en_reg  <= spi_en_next;
      tw_div_reg  <= tw_div_next;
      tw_en_reg   <= tw_en_next;
      page_lo_reg <= page_lo_next;
      page_hi_reg <= page_hi_next;
      mask_reg    <= mask_next;
      own_reg     <= own_next;
      setup_reg   <= setup_next;
      dbg_reg     <= dbg_next;
      inc_reg     <= inc_next;
      addr_reg    <= addr_next;
      wdat_reg    <= wdat_next;
      rdata_reg   <= rdata_next;
      iwr_reg     <= iwr_next;
      ird_reg     <= ird_next;
      aw_addr_reg <= aw_addr_next;
      aw_data_reg <= aw_data_next;
      aw_reg      <= aw_next;
    end
  end

  // ----------------------------------------
  // serial clock generators
  // ----------------------------------------
  hpcr_div_if spi_dv ();
  hpcr_div_if tw_dv ();
  assign spi_dv.ratio = spi_div_reg[3:0];                   // see RULE4
  assign spi_dv.run   = spi_en_reg[BIT_CLK_EN];             // see RULE7
  assign tw_dv.ratio  = tw_div_reg[3:0];                    // see RULE8
  assign tw_dv.run    = tw_en_reg[BIT_CLK_EN];

  hpcr_clk_div u_spi_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .dv      (spi_dv)
  );
  hpcr_clk_div u_tw_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .dv      (tw_dv)
  );

  logic spi_use_in1;
  logic tw_use_in1;
  logic spi_tick_reg;
  logic tw_tick_reg;
  logic spi_tick_next;
  logic tw_tick_next;
  always_comb begin
    spi_use_in1   = periph_clock_select_pin | spi_en_reg[BIT_SRC_SEL];  // see RULE6
    tw_use_in1    = two_wire_clock_select_pin | tw_en_reg[BIT_SRC_SEL]; // see RULE10
    spi_tick_next = spi_use_in1 ? input_clock_one_tick : spi_dv.tick;
    tw_tick_next  = tw_use_in1 ? input_clock_one_tick : tw_dv.tick;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_tick_reg <= 1'b0;
      tw_tick_reg  <= 1'b0;
    end else begin
      spi_tick_reg <= spi_tick_next;
      tw_tick_reg  <= tw_tick_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign host_rdata            = rdata_reg;
  assign first_pll_div_en      = pll_reg[BIT_PLL_DIV_EN];   // see RULE2
  assign first_pll_div_sel     = pll_reg[2:1];
  assign periph_clk_tick       = spi_tick_reg;
  assign two_wire_clk_tick     = tw_tick_reg;
  assign direct_addr_high      = {page_hi_reg, page_lo_reg, 16'h0000}; // see RULE11
  assign upper_addr_mask_field = mask_reg[4:0];             // see RULE12
  assign async_host_owner      = own_reg[0];
  assign read_setup_cycles     = setup_reg[2:0];            // see RULE16
  assign debug_pins_sel        = dbg_reg[BIT_DBG_PINS] & host_is_direct16_not_handheld; // see RULE17
  assign soft_reset            = dbg_reg[BIT_SOFT_RESET];
  assign indirect_addr         = addr_reg;
  assign indirect_wr           = iwr_reg;
  assign indirect_rd           = ird_reg;
  assign indirect_wdata        = wdat_reg;
  assign async_wr_addr         = aw_addr_reg;
  assign async_wr_data         = aw_data_reg;
  assign async_wr              = aw_reg;
endmodule
`default_nettype wire

// File: testbench/hpcr_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// register bank checker
// ----------------------------------------
module hpcr_regs_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // requests
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic [7:0]  host_addr,
  input wire logic [7:0]  host_wdata,
  input wire logic        internal_bus_wr,
  // pins
  input wire logic        periph_clock_select_pin,
  input wire logic        input_clock_one_tick,
  input wire logic        host_is_direct16_not_handheld,
  // outputs
  input wire logic        first_pll_div_en,
  input wire logic [1:0]  first_pll_div_sel,
  input wire logic        periph_clk_tick,
  input wire logic        async_host_owner,
  input wire logic [2:0]  read_setup_cycles,
  input wire logic        debug_pins_sel,
  input wire logic        indirect_wr,
  input wire logic        indirect_rd,
  input wire logic [15:0] indirect_wdata,
  input wire logic [7:0]  async_wr_addr,
  input wire logic [7:0]  async_wr_data,
  input wire logic        async_wr
);
  import hpcr_pkg::*;
  logic hit;
  assign hit = host_wr && host_addr >= OFF_ASYNC_FIRST && host_addr <= OFF_ASYNC_LAST;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_pfix;
    periph_clock_select_pin ##1 periph_clock_select_pin;
  endsequence
  sequence s_dbg;
    host_wr && host_addr == OFF_DBG_RESET && host_is_direct16_not_handheld
      ##1 host_is_direct16_not_handheld;
  endsequence
  a_pll_write: assert property (
    hit && host_addr == OFF_PLL_IN_DIV && async_host_owner |=> first_pll_div_en ==
      $past(host_wdata[0]) && first_pll_div_sel == $past(host_wdata[2:1]))
    else $error("pll field not taken");
  a_host_blocked: assert property (
    hit && !async_host_owner && !internal_bus_wr |=> !async_wr)
    else $error("host async write passed");
  a_host_async: assert property (
    hit && async_host_owner |=> async_wr && async_wr_addr == $past(host_addr) &&
      async_wr_data == $past(host_wdata))
    else $error("host async write lost");
  a_bus_blocked: assert property (
    internal_bus_wr && async_host_owner && !host_wr |=> !async_wr)
    else $error("bus write passed");
  a_owner_write: assert property (
    host_wr && host_addr == OFF_OWNERSHIP |=> async_host_owner == $past(host_wdata[0]))
    else $error("owner bit not taken");
  a_setup_write: assert property (
    host_wr && host_addr == OFF_RD_SETUP |=> read_setup_cycles == $past(host_wdata[2:0]))
    else $error("setup field not taken");
  a_debug_sel: assert property (
    s_dbg |-> debug_pins_sel == $past(host_wdata[1]))
    else $error("debug select wrong");
  a_port_write: assert property (
    host_wr && host_addr == OFF_DATA_HI |=> indirect_wr && indirect_wdata[15:8] ==
      $past(host_wdata))
    else $error("data port write lost");
  a_port_read: assert property (
    host_rd && !host_wr && host_addr == OFF_DATA_LO |=> indirect_rd)
    else $error("data port read lost");
  a_pin_forced: assert property (
    s_pfix |-> periph_clk_tick == $past(input_clock_one_tick))
    else $error("forced tick wrong");
endmodule
bind hpcr_regs hpcr_regs_asserts u_hpcr_regs_asserts (
  .ref_clk, .arst_n, .host_wr, .host_rd, .host_addr, .host_wdata, .internal_bus_wr,
  .periph_clock_select_pin, .input_clock_one_tick, .host_is_direct16_not_handheld,
  .first_pll_div_en, .first_pll_div_sel, .periph_clk_tick, .async_host_owner,
  .read_setup_cycles, .debug_pins_sel, .indirect_wr, .indirect_rd, .indirect_wdata,
  .async_wr_addr, .async_wr_data, .async_wr
);
`default_nettype wire

// File: testbench/hpcr_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// host processor model
// ----------------------------------------
module hpcr_host (
  // clock
  input  wire logic       ref_clk,
  // host register port
  output var logic        host_wr,
  output var logic        host_rd,
  output var logic [7:0]  host_addr,
  output var logic [7:0]  host_wdata,
  input  wire logic [7:0] host_rdata
);
  import hpcr_pkg::*;
  initial begin
    host_wr = 1'h0;
    host_rd = 1'h0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    if (a == OFF_RSVD_LO || a == OFF_RSVD_HI) return;
    @(posedge ref_clk);
    host_wr    <= 1'h1;
    host_addr  <= a;
    host_wdata <= v;
    @(posedge ref_clk);
    host_wr    <= 1'h0;
    host_addr  <= ~a;
    host_wdata <= ~v;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    host_rd   <= 1'h1;
    host_addr <= a;
    @(posedge ref_clk);
    host_rd   <= 1'h0;
    host_addr <= ~a;
    @(posedge ref_clk);
    #1 v = host_rdata;
  endtask
  // ratio change with the divider stopped
  task automatic pll_ratio(input logic [1:0] r);
    wr(OFF_PLL_IN_DIV, 8'h00);
    wr(OFF_PLL_IN_DIV, {5'h00, r, 1'h0});
    wr(OFF_PLL_IN_DIV, {5'h00, r, 1'h1});
  endtask
  task automatic soft_rst();
    wr(OFF_DBG_RESET, 8'h01);
    wr(OFF_DBG_RESET, 8'h00);
    wr(OFF_OWNERSHIP, 8'h01);
    wr(8'h24, 8'h01);
    wr(OFF_OWNERSHIP, 8'h00);
  endtask
endmodule
`default_nettype wire

// File: testbench/test_hpcr_regs.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// register bank testbench
// ----------------------------------------
module test_hpcr_regs;
  import hpcr_pkg::*;
  localparam logic [7:0] RA [8] = '{8'h60, 8'h62, 8'h80, 8'h81, 8'h82, 8'h85, 8'hA6, 8'h90};
  localparam logic [7:0] RR [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
  localparam logic [7:0] RE [8] = '{8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'h1F, 8'h07, 8'h01, 8'h00};
  localparam logic [7:0] AV [4] = '{8'h00, 8'h10, 8'h00, 8'h38};
  logic        ref_clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        internal_bus_wr = 1'h0;
  logic [7:0]  internal_bus_addr = 8'h00;
  logic [7:0]  internal_bus_wdata = 8'h00;
  logic        periph_clock_select_pin = 1'h0;
  logic        two_wire_clock_select_pin = 1'h0;
  logic        periph_clock_enable_pin = 1'h0;
  logic        two_wire_clock_enable_pin = 1'h0;
  logic        input_clock_one_tick = 1'h0;
  logic        host_is_direct16_not_handheld = 1'h1;
  logic [2:0]  ph = 3'h0;
  logic        host_wr;
  logic        host_rd;
  logic [7:0]  host_addr;
  logic [7:0]  host_wdata;
  logic [7:0]  host_rdata;
  logic        first_pll_div_en;
  logic [1:0]  first_pll_div_sel;
  logic        periph_clk_tick;
  logic        two_wire_clk_tick;
  logic [31:0] direct_addr_high;
  logic [4:0]  upper_addr_mask_field;
  logic        async_host_owner;
  logic [2:0]  read_setup_cycles;
  logic        debug_pins_sel;
  logic        soft_reset;
  logic [31:0] indirect_addr;
  int          mismatches = 0;
  int          cmp_count = 0;
  hpcr_regs u_hpcr_regs (
    .ref_clk, .arst_n, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata,
    .internal_bus_wr, .internal_bus_addr, .internal_bus_wdata,
    .periph_clock_select_pin, .two_wire_clock_select_pin, .periph_clock_enable_pin,
    .two_wire_clock_enable_pin, .input_clock_one_tick, .host_is_direct16_not_handheld,
    .first_pll_div_en, .first_pll_div_sel, .periph_clk_tick, .two_wire_clk_tick,
    .direct_addr_high, .upper_addr_mask_field, .async_host_owner, .read_setup_cycles,
    .debug_pins_sel, .soft_reset, .indirect_addr, .indirect_wr(), .indirect_rd(),
    .indirect_wdata(), .async_wr_addr(), .async_wr_data(), .async_wr()
  );
  hpcr_host u_hpcr_host (.ref_clk, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    ph                   <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
    input_clock_one_tick <= arst_n && ph == 3'h4;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_hpcr_host.rd(a, v);
    chk({24'h0, v}, {24'h0, e});
  endtask
  task automatic ib(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    internal_bus_wr    <= 1'h1;
    internal_bus_addr  <= a;
    internal_bus_wdata <= v;
    @(posedge ref_clk);
    internal_bus_wr    <= 1'h0;
    #1;
  endtask
  // set both dividers, then count ticks over 240 cycles
  task automatic tk(input logic [7:0] d0, input logic [7:0] e0, input logic [7:0] d1,
                    input logic [7:0] e1, input logic pin, input logic [31:0] ep,
                    input logic [31:0] et);
    logic [31:0] p;
    logic [31:0] t;
    u_hpcr_host.wr(OFF_SPI_DIV, d0);
    u_hpcr_host.wr(OFF_SPI_EN, e0);
    u_hpcr_host.wr(OFF_TW_DIV, d1);
    u_hpcr_host.wr(OFF_TW_EN, e1);
    periph_clock_select_pin   <= pin;
    two_wire_clock_select_pin <= pin;
    repeat (40) @(posedge ref_clk);
    p = 32'h0;
    t = 32'h0;
    repeat (240) begin
      @(posedge ref_clk);
      #1 p += {31'h0, periph_clk_tick === 1'h1};
      t += {31'h0, two_wire_clk_tick === 1'h1};
    end
    chk(p, ep);
    chk(t, et);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      rc(RA[i], RR[i]);
      u_hpcr_host.wr(RA[i], 8'hFF);
      rc(RA[i], RE[i]);
    end
    chk({27'h0, upper_addr_mask_field}, 32'h1F);
    u_hpcr_host.wr(OFF_PAGE_LO, 8'h34);
    u_hpcr_host.wr(OFF_PAGE_HI, 8'h12);
    chk(direct_addr_high, 32'h1234_0000);
    for (int i = 0; i < 4; i++) u_hpcr_host.wr(OFF_RW_ADDR0 + 8'(i), AV[i]);
    chk(indirect_addr, 32'h3800_1000);
    u_hpcr_host.wr(OFF_DATA_LO, 8'h34);
    u_hpcr_host.wr(OFF_DATA_HI, 8'h12);
    chk(indirect_addr, 32'h3800_1002);
    rc(OFF_DATA_LO, 8'h00);
    chk(indirect_addr, 32'h3800_1004);
    u_hpcr_host.wr(OFF_AUTO_INC, 8'h00);
    u_hpcr_host.wr(OFF_DATA_HI, 8'h56);
    chk(indirect_addr, 32'h3800_1004);
    ib(OFF_PLL_IN_DIV, 8'h07);
    chk({29'h0, first_pll_div_sel, first_pll_div_en}, 32'h7);
    u_hpcr_host.wr(OFF_PLL_IN_DIV, 8'h00);
    rc(OFF_PLL_IN_DIV, 8'h07);
    u_hpcr_host.wr(OFF_OWNERSHIP, 8'h01);
    u_hpcr_host.pll_ratio(2'h1);
    chk({29'h0, first_pll_div_sel, first_pll_div_en}, 32'h3);
    ib(OFF_PLL_IN_DIV, 8'h00);
    rc(OFF_PLL_IN_DIV, 8'h03);
    u_hpcr_host.wr(OFF_OWNERSHIP, 8'h00);
    tk(8'h03, 8'h01, 8'h00, 8'h01, 1'h0, 32'h3C, 32'hF0);
    tk(8'h0F, 8'h00, 8'h0F, 8'h01, 1'h0, 32'h00, 32'h0F);
    tk(8'h0F, 8'h05, 8'h0F, 8'h04, 1'h0, 32'h30, 32'h30);
    tk(8'h02, 8'h01, 8'h02, 8'h00, 1'h1, 32'h30, 32'h30);
    periph_clock_select_pin   <= 1'h0;
    two_wire_clock_select_pin <= 1'h0;
    periph_clock_enable_pin   <= 1'h1;
    two_wire_clock_enable_pin <= 1'h1;
    rc(OFF_SPI_EN, 8'h11);
    rc(OFF_TW_EN, 8'h10);
    u_hpcr_host.wr(OFF_DBG_RESET, 8'h02);
    chk({31'h0, debug_pins_sel}, 32'h1);
    host_is_direct16_not_handheld <= 1'h0;
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, debug_pins_sel}, 32'h0);
    host_is_direct16_not_handheld <= 1'h1;
    u_hpcr_host.wr(OFF_DBG_RESET, 8'h01);
    chk({31'h0, soft_reset}, 32'h1);
    u_hpcr_host.soft_rst();
    chk({30'h0, soft_reset, async_host_owner}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
